// ### bench/eia_exc_unit_chk.sv
// Port-level assertions for the exception unit
`timescale 1ns/100ps
`default_nettype none
module eia_exc_unit_chk (
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire logic        ext_irq_i,
  input wire logic        higher_exc_pend_i,
  input wire logic        pipe_empty_i,
  input wire logic [31:0] next_pc_i,
  input wire logic [31:0] acc_instr_i,
  input wire logic [31:0] acc_pc_i,
  input wire logic        acc_indexed_i,
  input wire logic        dispatch_stop_o,
  input wire logic        take_ext_o,
  input wire logic        take_align_o,
  input wire logic        take_dacc_o,
  input wire logic [31:0] vector_o,
  input wire logic [31:0] machine_state_o,
  input wire logic [31:0] saved_pc_o,
  input wire logic [31:0] saved_state_o,
  input wire logic [31:0] fault_cause_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  ext_cause_a: assert property (take_ext_o |-> $past(ext_irq_i & pipe_empty_i & ~higher_exc_pend_i))
    else $error("interrupt taken without a ready cause");
  drain_stop_a: assert property (take_ext_o |-> $past(dispatch_stop_o) && !dispatch_stop_o)
    else $error("interrupt taken without draining first");
  ext_pc_a: assert property (take_ext_o |-> saved_pc_o == $past(next_pc_i))
    else $error("saved pc wrong on interrupt");
  state_save_a: assert property ((take_ext_o | take_align_o) |-> saved_state_o == {16'h0, $past(machine_state_o[15:0])})
    else $error("saved state wrong");
  ms_clear_a: assert property ((take_ext_o | take_align_o) |-> (machine_state_o & 32'h0000_ED30) == 32'h0
    && machine_state_o[12] == $past(machine_state_o[12]) && machine_state_o[6] == $past(machine_state_o[6]))
    else $error("machine state not updated on entry");
  vec_sel_a: assert property ((take_ext_o | take_align_o) |-> vector_o == (($past(machine_state_o[6]) ?
    eia_pkg::BASE_HIGH : eia_pkg::BASE_LOW) | (take_ext_o ? eia_pkg::VEC_EXT_IRQ : eia_pkg::VEC_ALIGN)))
    else $error("vector wrong");
  align_pc_a: assert property (take_align_o |-> saved_pc_o == $past(acc_pc_i))
    else $error("saved pc wrong on alignment");
  fc_form_a: assert property (take_align_o |-> fault_cause_o[31:17] == 15'h0
    && fault_cause_o[16:15] == ($past(acc_indexed_i) ? $past(acc_instr_i[2:1]) : 2'h0))
    else $error("fault cause form bits wrong");
  fc_index_a: assert property (take_align_o |-> fault_cause_o[13:10] ==
    ($past(acc_indexed_i) ? $past(acc_instr_i[10:7]) : $past(acc_instr_i[30:27])))
    else $error("fault cause index bits wrong");
  fc_regs_a: assert property (take_align_o |-> fault_cause_o[9:0] == $past(acc_instr_i[25:16]))
    else $error("fault cause register fields wrong");
  dacc_only_a: assert property (take_dacc_o |-> !take_align_o)
    else $error("data access and alignment together");
endmodule
bind eia_exc_unit eia_exc_unit_chk u_eia_exc_unit_chk (.*);
`default_nettype wire

// ### bench/eia_irq_src.sv
// Model of the interrupt source facing the core's interrupt pin
`timescale 1ns/100ps
`default_nettype none
module eia_irq_src (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // Bench request and service pulse
  input  wire logic req_i,
  input  wire logic serviced_i,
  // Interrupt pin
  output logic      irq_o
);
  // Held until serviced, since the core may defer it for a long time
  always_ff @(posedge core_clk_i) begin
    if (srst_i || serviced_i) begin
      irq_o <= 1'b0;
    end else if (req_i) begin
      irq_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the exception unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        core_clk_i, srst_i, ext_irq_i, higher_exc_pend_i, pipe_empty_i, acc_valid_i, acc_indexed_i;
  logic        segment_io_flag_i, block_match_i, page_wt_i, block_ci_i, ms_wr_i, irq_req;
  logic        dispatch_stop_o, take_ext_o, take_align_o, take_dacc_o, acc_go_o;
  logic [2:0]  acc_op_i;
  logic [8:0]  bus_unit_id_i;
  logic [1:0]  acc_type_o;
  logic [31:0] next_pc_i, acc_ea_i, acc_len_i, acc_instr_i, acc_pc_i, ms_wdata_i, vector_o, machine_state_o;
  logic [31:0] saved_pc_o, saved_state_o, fault_cause_o, seed;
  logic [5:0]  q[$];
  logic [5:0]  exp_n;
  int          errors = 0, compares = 0, cyc = 0;

  eia_exc_unit u_eia_exc_unit (.*);
  eia_irq_src u_eia_irq_src (.core_clk_i(core_clk_i), .srst_i(srst_i), .req_i(irq_req),
                             .serviced_i(take_ext_o), .irq_o(ext_irq_i));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic ms_set(input logic [31:0] v);
    @(posedge core_clk_i);
    #1;
    {ms_wr_i, ms_wdata_i} = {1'b1, v};
    @(posedge core_clk_i);
    #1;
    ms_wr_i = 1'b0;
  endtask

  // Flags: translation, io segment, memory-forced, block match, write-through or cache-inhibit
  task automatic acc(input logic [2:0] op, input logic [31:0] ea, input logic [5:0] len, input logic [4:0] f,
                     input logic [3:0] k);
    ms_set({27'h0, f[4], 4'h0});
    seed = lfsr(seed);
    {acc_valid_i, acc_op_i, acc_ea_i, acc_len_i, segment_io_flag_i, block_match_i, page_wt_i, block_ci_i} =
      {1'b1, op, ea, 26'h0, len, f[3], f[1], f[0], f[0]};
    bus_unit_id_i = f[2] ? eia_pkg::BUS_UNIT_ID_MEM : {seed[8:7], 7'h10};
    {acc_instr_i, acc_pc_i, acc_indexed_i} = {seed, seed[15:0], seed[31:18], 2'h0, seed[3]};
    q.push_back({f[3] ? (f[2] ? 2'h2 : 2'h1) : ((f[4] & ~f[1]) ? 2'h3 : 2'h0), k});
    @(posedge core_clk_i);
    #1;
    acc_valid_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask

  // Every pulse must match the oldest noted outcome; a stray pulse finds the queue empty
  always @(negedge core_clk_i) begin
    if ({take_ext_o, take_dacc_o, take_align_o, acc_go_o} !== 4'h0) begin
      exp_n = (q.size() > 0) ? q.pop_front() : 6'h3F;
      chk("outcome", {26'h0, take_ext_o ? 2'h0 : acc_type_o, take_ext_o, take_dacc_o, take_align_o, acc_go_o},
          {26'h0, exp_n});
    end
  end

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    {srst_i, irq_req, higher_exc_pend_i, pipe_empty_i, acc_valid_i, acc_indexed_i, segment_io_flag_i, block_match_i,
     page_wt_i, block_ci_i, ms_wr_i, acc_op_i, acc_ea_i, acc_len_i, acc_instr_i, acc_pc_i, next_pc_i, bus_unit_id_i,
     ms_wdata_i} = '0;
    srst_i = 1'b1;
    seed = 32'h6688;
    repeat (3) @(posedge core_clk_i);
    #1;
    srst_i = 1'b0;
    acc(3'h0, 32'h0FFF_FFFE, 6'h04, 5'h00, 4'h2);
    acc(3'h0, 32'h0FFF_FFFC, 6'h04, 5'h00, 4'h1);
    acc(3'h4, 32'h1FFF_FFF0, 6'h20, 5'h10, 4'h2);
    acc(3'h1, 32'h0000_0100, 6'h08, 5'h08, 4'h2);
    acc(3'h2, 32'h0000_0100, 6'h04, 5'h08, 4'h4);
    acc(3'h3, 32'h0000_0100, 6'h04, 5'h18, 4'h4);
    acc(3'h1, 32'h0000_0102, 6'h08, 5'h0C, 4'h1);
    acc(3'h2, 32'h0000_0100, 6'h04, 5'h1C, 4'h1);
    acc(3'h0, 32'h0000_0FFF, 6'h01, 5'h10, 4'h1);
    acc(3'h0, 32'h0000_0FFF, 6'h02, 5'h10, 4'h2);
    acc(3'h0, 32'h0000_0FFD, 6'h04, 5'h10, 4'h2);
    acc(3'h0, 32'h0000_0FFC, 6'h04, 5'h10, 4'h1);
    acc(3'h0, 32'h0000_0FF9, 6'h08, 5'h10, 4'h2);
    acc(3'h3, 32'h0000_0FFC, 6'h08, 5'h10, 4'h2);
    acc(3'h4, 32'h0000_0FFC, 6'h08, 5'h10, 4'h1);
    acc(3'h4, 32'h0000_0FFE, 6'h04, 5'h10, 4'h2);
    acc(3'h0, 32'h0000_0FFD, 6'h04, 5'h12, 4'h2);
    acc(3'h5, 32'h0000_1000, 6'h20, 5'h11, 4'h2);
    acc(3'h5, 32'h0000_1000, 6'h20, 5'h13, 4'h2);
    acc(3'h5, 32'h0000_1000, 6'h20, 5'h10, 4'h1);
    seed = lfsr(seed);
    ms_set(32'h0000_0040);
    {irq_req, pipe_empty_i, higher_exc_pend_i, next_pc_i} = {3'h7, seed};
    repeat (10) @(posedge core_clk_i);
    #1;
    irq_req = 1'b0;
    ms_set(32'h0000_8050);
    repeat (10) @(posedge core_clk_i);
    #1;
    chk("stop", {31'h0, dispatch_stop_o}, 32'h0);
    {higher_exc_pend_i, pipe_empty_i} = 2'h0;
    repeat (5) @(posedge core_clk_i);
    #1;
    chk("stop", {31'h0, dispatch_stop_o}, 32'h1);
    q.push_back(6'h08);
    pipe_empty_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    chk("vector", vector_o, eia_pkg::BASE_HIGH | eia_pkg::VEC_EXT_IRQ);
    chk("saved_pc", saved_pc_o, seed);
    chk("saved_state", saved_state_o, 32'h0000_8050);
    chk("state", machine_state_o, 32'h0000_0040);
    chk("pending", q.size(), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire

// ### common/eia_pkg.sv
// Constants and types for the external interrupt and alignment exception unit
// Notes on behaviour
// - Hold an asserted interrupt while ext_irq_enable is clear or a higher exception pends.
// - On interrupt, stop dispatch, let pending instructions finish first, then take it.
// - Interrupt entry loads saved_pc with the next instruction address.
// - Either exception clears saved_state 0-15 and copies machine_state 16-31.
// - Entry clears the enable, mode, float, trace and translation bits; keeps two others.
// - Resume at base plus 0x500 for interrupt, base plus 0x600 for alignment.
// - Alignment entry loads saved_pc with the faulting instruction address.
// - Alignment clears fault_cause 0-14; bits 15-16 from instruction 29-30 if indexed.
// - Indexed: bit 17 from instr 25, 18-21 from 21-24; immediate: 18-21 from 1-4.
// - fault_cause 22-26 from instruction bits 6-10; undefined for cache_block_zero.
// - fault_cause 27-31 from instruction bits 11-15.
// - Range check happens before execution so a trapped instruction does nothing.
// - Classify access as direct, I/O, memory-forced or page from translation and segment.
// - Any 256-Mbyte crossing traps for every access type.
// - Floating-point access to a non-forced I/O segment always traps.
// - Reserve, conditional store and string compare to I/O give data access, not alignment.
// - Memory-forced segments get no special float or reserve cases.
// - Page mode plain operands trap when they span a 4-Kbyte boundary.
// - Page mode string_compare_load traps on any 4-Kbyte page crossing.
// - Page mode word-aligned strings trap only on 256-Mbyte; others on 4-Kbyte.
// - cache_block_zero traps when page write-through or block cache-inhibit is set.
// - Block-mapped accesses in page mode still get the 4-Kbyte checks; the code exempts block-mapped strings of any alignment.
package eia_pkg;
  // Bit positions in machine_state, counted from bit 0 as the msb
  localparam int unsigned MS_EE  = 16;
  localparam int unsigned MS_PR  = 17;
  localparam int unsigned MS_FP  = 18;
  localparam int unsigned MS_ME  = 19;
  localparam int unsigned MS_FE0 = 20;
  localparam int unsigned MS_SE  = 21;
  localparam int unsigned MS_FE1 = 23;
  localparam int unsigned MS_EP  = 25;
  localparam int unsigned MS_IT  = 26;
  localparam int unsigned MS_DT  = 27;
  localparam logic [31:0] VEC_EXT_IRQ = 32'h0000_0500;
  localparam logic [31:0] VEC_ALIGN   = 32'h0000_0600;
  localparam logic [31:0] BASE_LOW    = 32'h0000_0000;
  localparam logic [31:0] BASE_HIGH   = 32'hFFF0_0000;
  localparam logic [8:0]  BUS_UNIT_ID_MEM    = 9'h07F;
  localparam logic [31:0] MS_RESET    = 32'h0000_0000;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  typedef enum logic [1:0] {
    EIA_ACC_DIRECT,
    EIA_ACC_IO,
    EIA_ACC_FORCED,
    EIA_ACC_PAGE
  } eia_acc_e;
  typedef enum logic [2:0] {
    EIA_OP_INT,
    EIA_OP_FLOAT,
    EIA_OP_RESERVE,
    EIA_OP_STRCMP,
    EIA_OP_STRING,
    EIA_OP_DCBZ
  } eia_op_e;
endpackage

// ### rtl/eia_exc_unit.sv
// External interrupt and alignment exception unit
`timescale 1ns/100ps
`default_nettype none
module eia_exc_unit (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // Interrupt pin
  input  wire logic        ext_irq_i,
  // Pipeline status
  input  wire logic        higher_exc_pend_i,
  input  wire logic        pipe_empty_i,
  input  wire logic [31:0] next_pc_i,
  // Data access under check
  input  wire logic        acc_valid_i,
  input  wire logic [31:0] acc_ea_i,
  input  wire logic [31:0] acc_len_i,
  input  wire logic [2:0]  acc_op_i,
  input  wire logic [31:0] acc_instr_i,
  input  wire logic [31:0] acc_pc_i,
  input  wire logic        acc_indexed_i,
  input  wire logic        segment_io_flag_i,
  input  wire logic [8:0]  bus_unit_id_i,
  input  wire logic        block_match_i,
  input  wire logic        page_wt_i,
  input  wire logic        block_ci_i,
  // Software writes of machine_state
  input  wire logic        ms_wr_i,
  input  wire logic [31:0] ms_wdata_i,
  // Exception outputs
  output logic             dispatch_stop_o,
  output logic             take_ext_o,
  output logic             take_align_o,
  output logic             take_dacc_o,
  output logic             acc_go_o,
  output logic [31:0]      vector_o,
  output logic [1:0]       acc_type_o,
  output logic [31:0]      machine_state_o,
  output logic [31:0]      saved_pc_o,
  output logic [31:0]      saved_state_o,
  output logic [31:0]      fault_cause_o
);
  ////////////////////////////////////////////////////////////////////////
  // Access classification and range checks
  logic [31:0] ms_r;
  logic [31:0] last_ea;
  logic        ms_dt;
  logic        cross_256m;
  logic        cross_4k;
  logic        word_al;
  logic        str_op;
  logic        align_hit;
  logic        dacc_hit;
  logic        plain_4k;
  eia_pkg::eia_acc_e acc_t;
  eia_pkg::eia_op_e  op;

  localparam logic [31:0] ZERO = eia_pkg::ZERO32;

  assign ms_dt      = ms_r[31 - eia_pkg::MS_DT];
  assign op         = eia_pkg::eia_op_e'(acc_op_i);
  assign last_ea    = acc_ea_i + acc_len_i - 32'h0000_0001;
  // Comparing top bits covers string totals too, since acc_len is the whole transfer
  assign cross_256m = (acc_len_i != ZERO) && (last_ea[31:28] != acc_ea_i[31:28]);
  assign cross_4k   = (acc_len_i != ZERO) && (last_ea[31:12] != acc_ea_i[31:12]);
  assign word_al    = (acc_ea_i[1:0] == 2'h0);
  assign str_op     = (op == eia_pkg::EIA_OP_STRING);

  // Plain operands by size; lengths other than 1, 2, 4 and 8 fall back to the general crossing test
  always_comb begin
    case (acc_len_i)
      32'h0000_0001: begin
        plain_4k = 1'b0;
      end
      32'h0000_0002: begin
        plain_4k = (acc_ea_i[11:0] == 12'hFFF);
      end
      32'h0000_0004: begin
        plain_4k = (acc_ea_i[11:0] >= 12'hFFD);
      end
      32'h0000_0008: begin
        plain_4k = (acc_ea_i[11:0] >= 12'hFF9);
      end
      default: begin
        plain_4k = cross_4k;
      end
    endcase
  end

  always_comb begin
    if (segment_io_flag_i && bus_unit_id_i != eia_pkg::BUS_UNIT_ID_MEM) begin
      acc_t = eia_pkg::EIA_ACC_IO;
    end else if (segment_io_flag_i) begin
      acc_t = eia_pkg::EIA_ACC_FORCED;
    end else if (ms_dt && !block_match_i) begin
      acc_t = eia_pkg::EIA_ACC_PAGE;
    end else begin
      acc_t = eia_pkg::EIA_ACC_DIRECT;
    end
  end

  // Per-type verdicts, merged below, so each access type reads on its own
  logic io_align;
  logic io_dacc;
  logic forced_align;
  logic page_align;
  logic blk_align;
  logic dcbz_align;

  always_comb begin
    io_align = cross_256m;
    io_dacc  = 1'b0;
    if (op == eia_pkg::EIA_OP_FLOAT) begin
      io_align = 1'b1;
    end
    if (op == eia_pkg::EIA_OP_RESERVE || op == eia_pkg::EIA_OP_STRCMP) begin
      io_align = 1'b0;
      io_dacc  = 1'b1;
    end
  end

  // No float or reserve special cases here, only the segment crossing
  assign forced_align = cross_256m;

  always_comb begin
    if (op == eia_pkg::EIA_OP_STRCMP) begin
      page_align = cross_256m | cross_4k;
    end else if (str_op) begin
      page_align = cross_256m | (cross_4k & !word_al);
    end else begin
      page_align = cross_256m | plain_4k;
    end
  end

  // Block-mapped accesses in page mode keep the page checks, but strings of any alignment skip the 4-Kbyte test
  assign blk_align  = ms_dt && !segment_io_flag_i && block_match_i && !str_op && cross_4k;
  assign dcbz_align = (op == eia_pkg::EIA_OP_DCBZ) && ms_dt && !segment_io_flag_i &&
                      (block_match_i ? block_ci_i : page_wt_i);

  always_comb begin
    case (acc_t)
      eia_pkg::EIA_ACC_IO: begin
        align_hit = io_align;
        dacc_hit  = io_dacc;
      end
      eia_pkg::EIA_ACC_FORCED: begin
        align_hit = forced_align;
        dacc_hit  = 1'b0;
      end
      eia_pkg::EIA_ACC_PAGE: begin
        align_hit = page_align;
        dacc_hit  = 1'b0;
      end
      default: begin
        align_hit = cross_256m;
        dacc_hit  = 1'b0;
      end
    endcase
    if (blk_align || dcbz_align) begin
      align_hit = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt sequencing
  typedef enum logic [1:0] {
    EIA_ST_RUN,
    EIA_ST_DRAIN
  } eia_st_e;
  eia_st_e st_r;
  logic    ee;
  logic    do_ext;
  logic    do_align;
  logic    go_drain;
  logic    leave_drain;

  assign ee          = ms_r[31 - eia_pkg::MS_EE];
  // Alignment is a precise fault of an in-flight instruction, so it wins over the interrupt
  assign do_align    = acc_valid_i && align_hit && !higher_exc_pend_i;
  assign go_drain    = ext_irq_i && ee && !higher_exc_pend_i;
  assign do_ext      = (st_r == EIA_ST_DRAIN) && pipe_empty_i && go_drain && !do_align;
  // A dropped pin or a cleared enable cancels the drain rather than leaving dispatch stalled
  assign leave_drain = do_ext || !ext_irq_i || !ee || do_align;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_r <= EIA_ST_RUN;
    end else begin
      case (st_r)
        EIA_ST_RUN: begin
          if (go_drain) begin
            st_r <= EIA_ST_DRAIN;
          end
        end
        EIA_ST_DRAIN: begin
          if (leave_drain) begin
            st_r <= EIA_ST_RUN;
          end
        end
        default: st_r <= EIA_ST_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State save and vectoring
  logic [31:0] ms_entry;
  logic [31:0] base;
  always_comb begin
    ms_entry = ms_r;
    ms_entry[31 - eia_pkg::MS_EE]  = 1'b0;
    ms_entry[31 - eia_pkg::MS_PR]  = 1'b0;
    ms_entry[31 - eia_pkg::MS_FP]  = 1'b0;
    ms_entry[31 - eia_pkg::MS_FE0] = 1'b0;
    ms_entry[31 - eia_pkg::MS_FE1] = 1'b0;
    ms_entry[31 - eia_pkg::MS_SE]  = 1'b0;
    ms_entry[31 - eia_pkg::MS_IT]  = 1'b0;
    ms_entry[31 - eia_pkg::MS_DT]  = 1'b0;
  end
  assign base = ms_r[31 - eia_pkg::MS_EP] ? eia_pkg::BASE_HIGH : eia_pkg::BASE_LOW;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ms_r <= eia_pkg::MS_RESET;
    end else if (do_align || do_ext) begin
      ms_r <= ms_entry;
    end else if (ms_wr_i) begin
      ms_r <= ms_wdata_i;
    end
  end

  // Alignment names the faulting instruction, the interrupt the one that would run next
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      saved_pc_o <= eia_pkg::ZERO32;
    end else if (do_align) begin
      saved_pc_o <= acc_pc_i;
    end else if (do_ext) begin
      saved_pc_o <= next_pc_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      saved_state_o <= eia_pkg::ZERO32;
    end else if (do_align || do_ext) begin
      saved_state_o <= {16'h0000, ms_r[15:0]};
    end
  end

  // OR stands in for the add, since both bases are far coarser than the offsets
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      vector_o <= eia_pkg::ZERO32;
    end else if (do_align) begin
      vector_o <= base | eia_pkg::VEC_ALIGN;
    end else if (do_ext) begin
      vector_o <= base | eia_pkg::VEC_EXT_IRQ;
    end
  end

  // Bit n of the cause word sits at vector index 31-n; instruction likewise
  function automatic logic ib(input logic [31:0] w, input int unsigned n);
    ib = w[31 - n];
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      fault_cause_o <= eia_pkg::ZERO32;
    end else if (do_align) begin
      fault_cause_o[31:17] <= 15'h0000;
      fault_cause_o[16]    <= acc_indexed_i ? ib(acc_instr_i, 29) : 1'b0;
      fault_cause_o[15]    <= acc_indexed_i ? ib(acc_instr_i, 30) : 1'b0;
      fault_cause_o[14]    <= acc_indexed_i ? ib(acc_instr_i, 25) : 1'b0;
      fault_cause_o[13:10] <= acc_indexed_i ? acc_instr_i[10:7] : acc_instr_i[30:27];
      fault_cause_o[9:5]   <= acc_instr_i[25:21];
      fault_cause_o[4:0]   <= acc_instr_i[20:16];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered status outputs
  // Dispatch stops on the edge that starts the drain, so at least one stalled cycle precedes the take
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dispatch_stop_o <= 1'b0;
    end else if (st_r == EIA_ST_RUN) begin
      dispatch_stop_o <= go_drain;
    end else begin
      dispatch_stop_o <= !leave_drain;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      take_ext_o <= 1'b0;
    end else begin
      take_ext_o <= do_ext;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      take_align_o <= 1'b0;
    end else begin
      take_align_o <= do_align;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      take_dacc_o <= 1'b0;
    end else begin
      take_dacc_o <= acc_valid_i && dacc_hit && !align_hit;
    end
  end

  // An access may proceed only after the checks pass, before any part executes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      acc_go_o <= 1'b0;
    end else begin
      acc_go_o <= acc_valid_i && !align_hit && !dacc_hit;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      acc_type_o <= 2'h0;
    end else begin
      acc_type_o <= acc_t;
    end
  end

  assign machine_state_o = ms_r;
endmodule
`default_nettype wire
